// ### logic/pmst_fifo.sv
// small synchronous fifo with registered read data
`timescale 1ns/1ps
module pmst_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [WIDTH-1:0] mem_q [DEPTH]; // storage array
  logic [AW-1:0] wr_ptr_q; // next slot to write
  logic [AW-1:0] rd_ptr_q; // next slot to read
  logic [CW-1:0] cnt_q; // words held in the array
  logic in_ready_q; // registered not-full
  logic out_valid_q; // output stage holds a word
  logic [WIDTH-1:0] out_data_q; // output stage word

  wire push = in_valid & in_ready_q;
  // refill the output stage when it is empty or being taken
  wire pop = (cnt_q != '0) & (~out_valid_q | out_ready);
  wire [CW-1:0] cnt_d = cnt_q + CW'(push) - CW'(pop);

  // array write, no reset needed for data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers, count and full flag
  always_ff @(posedge clk) begin
    if (!reset_n || flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
      in_ready_q <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_q + AW'(push);
      rd_ptr_q <= rd_ptr_q + AW'(pop);
      cnt_q <= cnt_d;
      in_ready_q <= (cnt_d != CW'(DEPTH)); // honest full from the next count, so never a cycle late
    end
  end

  // output register stage
  always_ff @(posedge clk) begin
    if (!reset_n || flush) begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else if (pop) begin
      out_valid_q <= 1'b1;
      out_data_q <= mem_q[rd_ptr_q];
    end else if (out_ready) begin
      out_valid_q <= 1'b0;
    end
  end

  assign in_ready = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_data = out_data_q;
endmodule

// ### logic/pmst_pkg.sv
// constants and types shared by the mii status timing block
package pmst_pkg;
  localparam int CLK_NS = 100; // clk period in ns
  localparam int BIT_NS_10M = 100; // one bit time at 10 mbit
  localparam int BIT_NS_100M = 10; // one bit time at 100 mbit

  // least time in ns to whole cycles, rounded up, never below one
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // longest time in ns to whole cycles, rounded down, never below one
  function automatic int cyc_dn(input int ns);
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // transmit side carrier timing, in bit times
  localparam int CRS_ON_10M_MAX_BT = 2;
  localparam int CRS_OFF_10M_TYP_BT = 2;
  localparam int CRS_OFF_10M_MAX_BT = 4;
  localparam int CRS_ON_100M_MAX_BT = 4;
  localparam int CRS_OFF_10M_CYC = cyc_dn(CRS_OFF_10M_TYP_BT * BIT_NS_10M);

  // receive side delays at 100 mbit, in bit times
  localparam int RXLAT_TYP_BT = 16;
  localparam int RXLAT_MAX_BT = 17;
  localparam int J_CRS_MIN_BT = 10;
  localparam int J_CRS_MAX_BT = 14;
  localparam int J_COL_MIN_BT = 9;
  localparam int J_COL_MAX_BT = 13;
  localparam int T_CRS_MIN_BT = 13;
  localparam int T_CRS_MAX_BT = 18;
  localparam int T_COL_MIN_BT = 13;
  localparam int T_COL_MAX_BT = 18;
  localparam int J_CRS_CYC = cyc_up(J_CRS_MIN_BT * BIT_NS_100M);
  localparam int J_COL_CYC = cyc_up(J_COL_MIN_BT * BIT_NS_100M);
  localparam int T_CRS_CYC = cyc_up(T_CRS_MIN_BT * BIT_NS_100M);
  localparam int T_COL_CYC = cyc_up(T_COL_MIN_BT * BIT_NS_100M);
  localparam int RX_HIST_W = 4; // depth of the line activity history

  // heartbeat timing in ns
  localparam int HB_DLY_TYP_NS = 850;
  localparam int HB_DLY_MAX_NS = 1500;
  localparam int HB_LEN_TYP_NS = 1000;
  localparam int HB_LEN_MAX_NS = 1500;
  localparam int HB_DLY_CYC = cyc_up(HB_DLY_TYP_NS);
  localparam int HB_LEN_CYC = cyc_up(HB_LEN_TYP_NS);

  // reset timing
  localparam int POR_MIN_MS = 40;
  localparam int POR_TYP_MS = 45;
  localparam int POR_MAX_MS = 500;
  localparam int ISO_TYP_NS = 60;
  localparam int HWRST_MIN_NS = 500;
  localparam int TXCLK_TYP_MS = 35;
  localparam int TXCLK_MAX_MS = 500;
  localparam int HWRST_MIN_CYC = cyc_up(HWRST_MIN_NS);
  localparam int POR_TYP_CYC = POR_TYP_MS * (1000000 / CLK_NS);
  localparam int TXCLK_TYP_CYC = TXCLK_TYP_MS * (1000000 / CLK_NS);
  localparam int RST_CNT_W = 24;

  // transmit buffer
  localparam int NIB_W = 4;
  localparam int TXF_DEPTH = 16;

  // device state after supply or pin reset
  typedef enum logic [1:0] {
    PMST_POR,
    PMST_ISO,
    PMST_INIT,
    PMST_RUN
  } pmst_state_t;

  // heartbeat sequencer
  typedef enum logic [1:0] {
    PMST_HB_IDLE,
    PMST_HB_WAIT,
    PMST_HB_PULSE
  } pmst_hb_t;
endpackage

// ### logic/pmst_top.sv
// mii carrier, collision, heartbeat and reset sequencing of the phy
`timescale 1ns/1ps
module pmst_top
  import pmst_pkg::*;
#(
  parameter int POR_CYC = POR_TYP_CYC,
  parameter int TXCLK_CYC = TXCLK_TYP_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hw_reset_low,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic link_clk,
  input wire logic tx_en,
  input wire logic [NIB_W-1:0] tx_data,
  input wire logic line_receive_pair,
  input wire logic line_tx_ready,
  output logic [NIB_W-1:0] line_transmit_pair,
  output logic line_tx_valid,
  output logic tx_fifo_ready,
  output logic crs,
  output logic col,
  output logic isolate,
  output logic tx_clk_valid
);
  // two-flop synchronisers for every pin; stage one read only by stage two
  logic [10:0] sync1_q; // first stage
  logic [10:0] sync2_q; // second stage, safe to read
  // mode straps are pins too, so they pass the same two flops
  wire [10:0] pins = {full_duplex, speed_100, tx_data, tx_en, link_clk, line_receive_pair,
                      line_tx_ready, hw_reset_low};

  // synchronise all pins together
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_q <= 11'h001;
      sync2_q <= 11'h001;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  wire rst_pin_low = ~sync2_q[0]; // reset pin active
  wire line_ready_s = sync2_q[1]; // line accepts a nibble
  wire line_act_s = sync2_q[2]; // stream present between start and end symbols
  wire link_clk_s = sync2_q[3];
  wire tx_en_s = sync2_q[4];
  wire [NIB_W-1:0] tx_data_s = sync2_q[8:5];
  wire speed_s = sync2_q[9]; // synced speed strap, high at 100 mbit
  wire full_dup_s = sync2_q[10]; // synced duplex strap

  // link clock edge finder on the synchronised copy
  logic link_clk_prev_q; // link clock one cycle ago
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      link_clk_prev_q <= 1'b0;
    end else begin
      link_clk_prev_q <= link_clk_s;
    end
  end
  wire link_rise = link_clk_s & ~link_clk_prev_q;

  // reset sequencer
  pmst_state_t state_q; // device reset state
  logic [RST_CNT_W-1:0] rst_cnt_q; // wait counter for reset phases
  logic [3:0] low_cnt_q; // cycles the reset pin has been low
  logic isolate_q; // isolation output
  logic tx_clk_valid_q; // transmit clock valid output

  wire rst_seen = (low_cnt_q >= 4'(HWRST_MIN_CYC - 1)) & rst_pin_low;
  wire run = (state_q == PMST_RUN);
  wire half_dup = ~full_dup_s;

  // count how long the reset pin stays low; short glitches are ignored
  always_ff @(posedge clk) begin
    if (!reset_n || !rst_pin_low) begin
      low_cnt_q <= '0;
    end else if (!rst_seen) begin
      low_cnt_q <= low_cnt_q + 4'h1;
    end
  end

  // power-on wait straight to run; pin reset gives isolation, then initialization until the clock is good
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= PMST_POR;
      rst_cnt_q <= '0;
    end else if (rst_seen) begin
      state_q <= PMST_ISO;
      rst_cnt_q <= '0;
    end else begin
      case (state_q)
        PMST_POR: begin
          // supply threshold is taken as the release of reset_n
          if (rst_cnt_q == RST_CNT_W'(POR_CYC - 1)) begin
            state_q <= PMST_RUN;
          end else begin
            rst_cnt_q <= rst_cnt_q + 1'b1;
          end
        end
        PMST_ISO: begin
          // pin released: rst_seen dropped
          state_q <= PMST_INIT;
        end
        PMST_INIT: begin
          if (rst_cnt_q == RST_CNT_W'(TXCLK_CYC - 1)) begin
            state_q <= PMST_RUN;
          end else begin
            rst_cnt_q <= rst_cnt_q + 1'b1;
          end
        end
        default: begin
          rst_cnt_q <= '0;
        end
      endcase
    end
  end

  // isolation and clock valid flags
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      isolate_q <= 1'b1;
      tx_clk_valid_q <= 1'b0;
    end else begin
      isolate_q <= (state_q != PMST_RUN) | rst_seen;
      tx_clk_valid_q <= run & ~rst_seen;
    end
  end

  // transmit enable as sampled on link clock rising edges
  logic tx_act_q; // mac is transmitting
  always_ff @(posedge clk) begin
    if (!reset_n || !run) begin
      tx_act_q <= 1'b0;
    end else if (link_rise) begin
      tx_act_q <= tx_en_s;
    end
  end
  logic tx_act_prev_q; // previous transmit state
  wire tx_stop = ~tx_act_q & tx_act_prev_q;
  // one cycle copy of the transmit state finds its end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_act_prev_q <= 1'b0;
    end else begin
      tx_act_prev_q <= tx_act_q;
    end
  end

  // transmit carrier tail: 10 mbit holds carrier two bits after stop
  logic [2:0] crs_tail_q; // remaining cycles of carrier after stop
  always_ff @(posedge clk) begin
    if (!reset_n || tx_act_q) begin
      crs_tail_q <= '0;
    end else if (tx_stop && !speed_s) begin
      crs_tail_q <= 3'(CRS_OFF_10M_CYC - 1);
    end else if (crs_tail_q != '0) begin
      crs_tail_q <= crs_tail_q - 3'h1;
    end
  end
  // carrier from own transmission, half duplex only; one cycle from sample
  wire crs_tx = half_dup & (tx_act_q | (tx_stop & ~speed_s) | (crs_tail_q != '0));

  // line activity history: rises mark start symbols, falls mark end symbols
  logic [RX_HIST_W-1:0] rx_hist_q; // delayed copies of line activity
  always_ff @(posedge clk) begin
    if (!reset_n || !run) begin
      rx_hist_q <= '0;
    end else begin
      rx_hist_q <= {rx_hist_q[RX_HIST_W-2:0], line_act_s};
    end
  end
  // early tap sets, late tap holds on past the end symbol
  wire crs_rx = rx_hist_q[J_CRS_CYC-1] | rx_hist_q[T_CRS_CYC-1];
  wire col_rx = rx_hist_q[J_COL_CYC-1] | rx_hist_q[T_COL_CYC-1];
  // collision only when own transmission meets a stream at 100 mbit
  wire col_100 = speed_s & half_dup & tx_act_q & col_rx;

  // heartbeat after each 10 mbit half duplex transmission
  pmst_hb_t hb_q; // heartbeat state
  logic [3:0] hb_cnt_q; // heartbeat phase counter
  always_ff @(posedge clk) begin
    if (!reset_n || !run) begin
      hb_q <= PMST_HB_IDLE;
      hb_cnt_q <= '0;
    end else begin
      case (hb_q)
        PMST_HB_IDLE: begin
          if (tx_stop && !speed_s && half_dup) begin
            hb_q <= PMST_HB_WAIT;
            hb_cnt_q <= 4'(HB_DLY_CYC - 2); // output flop adds one
          end
        end
        PMST_HB_WAIT: begin
          if (hb_cnt_q == '0) begin
            hb_q <= PMST_HB_PULSE;
            hb_cnt_q <= 4'(HB_LEN_CYC - 1);
          end else begin
            hb_cnt_q <= hb_cnt_q - 4'h1;
          end
        end
        PMST_HB_PULSE: begin
          if (hb_cnt_q == '0) begin
            hb_q <= PMST_HB_IDLE;
          end else begin
            hb_cnt_q <= hb_cnt_q - 4'h1;
          end
        end
        default: begin
          hb_q <= PMST_HB_IDLE;
        end
      endcase
    end
  end
  wire hb_col = (hb_q == PMST_HB_PULSE);

  // status outputs, one flop each
  logic crs_q; // carrier sense
  logic col_q; // collision
  always_ff @(posedge clk) begin
    if (!reset_n || !run) begin
      crs_q <= 1'b0;
      col_q <= 1'b0;
    end else begin
      crs_q <= crs_tx | crs_rx;
      col_q <= col_100 | hb_col;
    end
  end

  // transmit nibbles taken on link clock edges into the buffer; the line
  // drains it, and a stalled line shows as tx_fifo_ready low to the mac
  wire txf_push = run & link_rise & tx_en_s;
  logic txf_in_ready; // buffer can take a nibble
  logic txf_out_valid; // buffer holds a nibble for the line
  logic [NIB_W-1:0] txf_out_data; // nibble towards the line
  pmst_fifo #(
    .WIDTH(NIB_W),
    .DEPTH(TXF_DEPTH)
  ) u_txf (
    .clk(clk),
    .reset_n(reset_n),
    .flush(~run),
    .in_valid(txf_push),
    .in_ready(txf_in_ready),
    .in_data(tx_data_s),
    .out_valid(txf_out_valid),
    .out_ready(line_ready_s),
    .out_data(txf_out_data)
  );

  assign line_transmit_pair = txf_out_data;
  assign line_tx_valid = txf_out_valid;
  assign tx_fifo_ready = txf_in_ready;
  assign crs = crs_q;
  assign col = col_q;
  assign isolate = isolate_q;
  assign tx_clk_valid = tx_clk_valid_q;
endmodule

// ### tb/pmst_checker.sv
// port assertions of the mii status timing block
`timescale 1ns/1ps
module pmst_checker
  import pmst_pkg::*;
#(
  parameter int POR_CYC = 50,
  parameter int TXCLK_CYC = 40
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hw_reset_low,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic link_clk,
  input wire logic tx_en,
  input wire logic [NIB_W-1:0] tx_data,
  input wire logic line_receive_pair,
  input wire logic line_tx_ready,
  input wire logic [NIB_W-1:0] line_transmit_pair,
  input wire logic line_tx_valid,
  input wire logic tx_fifo_ready,
  input wire logic crs,
  input wire logic col,
  input wire logic isolate,
  input wire logic tx_clk_valid
);
  localparam int POR_LO = POR_CYC - 2; // wait counts from the release of reset_n
  localparam int TXC_LO = TXCLK_CYC - 2;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_por;
    $rose(reset_n) |-> isolate ##POR_LO isolate ##[1:5] !isolate;
  endproperty
  a_por: assert property (p_por)
    else $error("power-on wait length wrong");
  property p_iso;
    $fell(hw_reset_low) ##1 !hw_reset_low [*7] |-> ##[0:2] (isolate && !tx_clk_valid && !crs);
  endproperty
  a_iso: assert property (p_iso)
    else $error("reset pin did not isolate");
  property p_txclk;
    $rose(hw_reset_low) && isolate |-> ##TXC_LO !tx_clk_valid ##[1:8] tx_clk_valid;
  endproperty
  a_txclk: assert property (p_txclk)
    else $error("transmit clock valid timing wrong");
  property p_crs_tx;
    $rose(link_clk) && tx_en && !full_duplex && !isolate && hw_reset_low |-> ##[1:6] crs;
  endproperty
  a_crs_tx: assert property (p_crs_tx)
    else $error("carrier not raised by transmit");
  property p_crs_off10;
    $rose(link_clk) && !tx_en && !speed_100 && !line_receive_pair && !isolate |-> ##8 !crs;
  endproperty
  a_crs_off10: assert property (p_crs_off10)
    else $error("carrier held after transmit");
  property p_crs_rx;
    $rose(line_receive_pair) && speed_100 && !isolate |-> ##[2:6] crs;
  endproperty
  a_crs_rx: assert property (p_crs_rx)
    else $error("carrier not raised by stream");
  property p_col_rx;
    $rose(line_receive_pair) && tx_en && speed_100 && !full_duplex && !isolate |-> ##[2:6] col;
  endproperty
  a_col_rx: assert property (p_col_rx)
    else $error("collision not raised");
  property p_crs_end;
    $fell(line_receive_pair) && speed_100 && !tx_en && crs |-> crs [*2] ##5 !crs;
  endproperty
  a_crs_end: assert property (p_crs_end)
    else $error("carrier release timing wrong");
  property p_col_end;
    $fell(line_receive_pair) && speed_100 && col |-> col [*2] ##5 !col;
  endproperty
  a_col_end: assert property (p_col_end)
    else $error("collision release timing wrong");
  property p_hb_dly;
    $fell(tx_en) && !speed_100 && !full_duplex && !isolate |-> ##[1:15] col;
  endproperty
  a_hb_dly: assert property (p_hb_dly)
    else $error("heartbeat late");
  property p_hb_len;
    $rose(col) && !speed_100 |-> col [*5] ##[1:10] !col;
  endproperty
  a_hb_len: assert property (p_hb_len)
    else $error("heartbeat length wrong");
endmodule
bind pmst_top pmst_checker #(.POR_CYC(POR_CYC), .TXCLK_CYC(TXCLK_CYC)) chk_u (
  .clk(clk), .reset_n(reset_n), .hw_reset_low(hw_reset_low), .speed_100(speed_100),
  .full_duplex(full_duplex), .link_clk(link_clk), .tx_en(tx_en), .tx_data(tx_data),
  .line_receive_pair(line_receive_pair), .line_tx_ready(line_tx_ready),
  .line_transmit_pair(line_transmit_pair), .line_tx_valid(line_tx_valid),
  .tx_fifo_ready(tx_fifo_ready), .crs(crs), .col(col), .isolate(isolate),
  .tx_clk_valid(tx_clk_valid));

// ### tb/pmst_line_model.sv
// line side model: takes transmit nibbles with one ready pulse each
`timescale 1ns/1ps
module pmst_line_model
  import pmst_pkg::*;
(
  input wire logic clk,
  input wire logic stall,
  input wire logic [NIB_W-1:0] line_transmit_pair,
  input wire logic line_tx_valid,
  output logic line_tx_ready,
  output logic got,
  output logic [NIB_W-1:0] got_nib
);
  // ready is synced inside, so pulses stay well apart to count one each
  initial begin
    line_tx_ready = 1'h0;
    got = 1'h0;
    got_nib = 4'h0;
    forever begin
      @(negedge clk);
      if (line_tx_valid && !stall) begin
        got_nib = line_transmit_pair;
        got = 1'h1;
        line_tx_ready = 1'h1;
        // ready stands one cycle only, else the buffer drains several nibbles
        @(negedge clk);
        got = 1'h0;
        line_tx_ready = 1'h0;
        repeat (6) @(negedge clk);
      end
    end
  end
endmodule

// ### tb/pmst_top_test.sv
// self-checking bench of the mii status timing block
`timescale 1ns/1ps
module pmst_top_test;
  import pmst_pkg::*;
  localparam int POR = 50; // shortened power-on wait
  localparam int TXC = 40; // shortened pin reset wait
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic hw_reset_low = 1'h1;
  logic speed_100 = 1'h1;
  logic full_duplex = 1'h0;
  logic link_clk = 1'h0;
  logic tx_en = 1'h0;
  logic [NIB_W-1:0] tx_data = 4'h0;
  logic line_receive_pair = 1'h0;
  logic stall = 1'h0; // far side refuses nibbles
  logic line_tx_ready, line_tx_valid, tx_fifo_ready, crs, col, isolate, tx_clk_valid, got;
  logic [NIB_W-1:0] line_transmit_pair, got_nib;
  logic [NIB_W-1:0] exp_q[$]; // nibbles expected on the line
  logic [31:0] seed = 32'h011e_3590;
  int bad_count = 0;
  int n_tests = 0;
  int dly, len;
  always #50 clk = ~clk;
  pmst_top #(.POR_CYC(POR), .TXCLK_CYC(TXC)) dut_u (.clk(clk), .reset_n(reset_n),
    .hw_reset_low(hw_reset_low), .speed_100(speed_100), .full_duplex(full_duplex),
    .link_clk(link_clk), .tx_en(tx_en), .tx_data(tx_data),
    .line_receive_pair(line_receive_pair), .line_tx_ready(line_tx_ready),
    .line_transmit_pair(line_transmit_pair), .line_tx_valid(line_tx_valid),
    .tx_fifo_ready(tx_fifo_ready), .crs(crs), .col(col), .isolate(isolate),
    .tx_clk_valid(tx_clk_valid));
  pmst_line_model line_u (.clk(clk), .stall(stall), .line_transmit_pair(line_transmit_pair),
    .line_tx_valid(line_tx_valid), .line_tx_ready(line_tx_ready), .got(got),
    .got_nib(got_nib));
  // xorshift source of nibble values
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk_bit(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_nib(input logic [NIB_W-1:0] g, input logic [NIB_W-1:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // one 800 ns transmit clock period; it stands still between calls
  task automatic link_cyc(input logic en, input logic [NIB_W-1:0] d);
    repeat (4) @(negedge clk);
    link_clk = 1'h0;
    repeat (4) @(negedge clk);
    link_clk = 1'h1;
    tx_en = en;
    tx_data = d;
  endtask
  // n random nibbles; only the first keep of them fit the buffer
  task automatic frame(input int n, input int keep);
    logic [NIB_W-1:0] d;
    for (int i = 0; i < n; i++) begin
      d = 4'(xs());
      link_cyc(1'h1, d);
      if (i < keep) exp_q.push_back(d);
    end
    link_cyc(1'h0, 4'h0);
  endtask
  // heartbeat delay and length in clock cycles, capped at 40
  task automatic hb_meas();
    dly = 0;
    len = 0;
    while (col !== 1'h1 && dly < 40) begin
      @(negedge clk);
      dly++;
    end
    while (col === 1'h1 && len < 40) begin
      @(negedge clk);
      len++;
    end
  endtask
  // scoreboard: oldest expected nibble against each one taken by the line
  always @(posedge clk) begin
    if (got === 1'h1) chk_nib(got_nib, exp_q.size() > 0 ? exp_q.pop_front() : 4'hx);
  end
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
  initial begin
    repeat (4) @(negedge clk);
    reset_n = 1'h1;
    repeat (POR - 2) @(negedge clk);
    chk_bit(isolate, 1'h1);
    repeat (8) @(negedge clk);
    chk_bit(isolate, 1'h0);
    chk_bit(tx_clk_valid, 1'h1);
    // 10 mbit, half then full duplex: carrier and heartbeat only in half
    for (int fd = 0; fd < 2; fd++) begin
      speed_100 = 1'h0;
      full_duplex = 1'(fd);
      repeat (4) @(negedge clk);
      frame(3, 3);
      chk_bit(crs, 1'(!fd));
      hb_meas();
      chk_bit(1'(dly <= 15), 1'(!fd));
      chk_bit(1'(len >= 5 && len <= 15), 1'(!fd));
      chk_bit(crs, 1'h0);
      repeat (20) @(negedge clk);
    end
    // 100 mbit transmit: carrier follows, no heartbeat
    speed_100 = 1'h1;
    full_duplex = 1'h0;
    repeat (4) @(negedge clk);
    frame(4, 4);
    chk_bit(crs, 1'h1);
    repeat (6) @(negedge clk);
    chk_bit(crs, 1'h0);
    chk_bit(col, 1'h0);
    // received stream alone, then while sending
    for (int tx = 0; tx < 2; tx++) begin
      if (tx == 1) begin
        exp_q.push_back(4'ha);
        link_cyc(1'h1, 4'ha);
        repeat (4) @(negedge clk);
      end
      line_receive_pair = 1'h1;
      repeat (6) @(negedge clk);
      chk_bit(crs, 1'h1);
      chk_bit(col, 1'(tx));
      line_receive_pair = 1'h0;
      repeat (7) @(negedge clk);
      chk_bit(col, 1'h0);
      chk_bit(crs, 1'(tx));
      if (tx == 1) link_cyc(1'h0, 4'h0);
      repeat (10) @(negedge clk);
    end
    // buffer filled against a stalled line, then drained in order
    stall = 1'h1;
    frame(20, TXF_DEPTH + 1);
    chk_bit(tx_fifo_ready, 1'h0);
    chk_bit(line_tx_valid, 1'h1);
    stall = 1'h0;
    for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(negedge clk);
    repeat (10) @(negedge clk);
    chk_bit(line_tx_valid, 1'h0);
    chk_bit(tx_fifo_ready, 1'h1);
    // pin reset: short pulse ignored, long pulse isolates
    hw_reset_low = 1'h0;
    repeat (2) @(negedge clk);
    hw_reset_low = 1'h1;
    repeat (10) @(negedge clk);
    chk_bit(isolate, 1'h0);
    hw_reset_low = 1'h0;
    repeat (10) @(negedge clk);
    chk_bit(isolate, 1'h1);
    chk_bit(tx_clk_valid, 1'h0);
    hw_reset_low = 1'h1;
    repeat (TXC + 8) @(negedge clk);
    chk_bit(tx_clk_valid, 1'h1);
    chk_bit(isolate, 1'h0);
    give_verdict();
  end
endmodule
